// ---- logic/odsc_serial_command.sv ----
// serial front end and double-buffered code registers of an octal converter
// Operation
// [RL1] frame: command, address, data, msb first
// [RL2] shift serial_in on falling clock while selected
// [RL3] execute decoded command on select rising
// [RL4] short frames still execute
// [RL5] host keeps select high 20 ns
// [RL6] strobe falling while deselected loads converters
// [RL7] 0001 writes input, transparent when strobe low
// [RL8] 0010 copies input to converter registers
// [RL9] 0011 writes input and converter directly
// [RL10] 1000 bit 0 sets chain mode
// [RL11] chain mode shifts overflow bits to serial_out
// [RL12] host sends 24 times N clocks
// [RL13] select rising latches frame, stops shifting
// [RL14] continuous or gated serial clock allowed
// [RL15] 1001 arms readback of addressed input register
// [RL16] readback enables serial_out even standalone
// [RL17] next frame shifts readback word out
// [RL18] serial_out holds last bit while deselected
// [RL19] 0100 loads sixteen bit power field
// [RL20] mode codes: normal, pull down, high impedance
// [RL21] powered-down channels keep and accept codes
// [RL22] strobe low 0001 updates both registers
// [RL23] each channel has input and converter stage
// [RL24] 0101 loads mask; masked ignore strobe
// [RL25] strobe falling after 0001 transfers unmasked
// [RL26] nop and reserved codes change nothing
`include "odsc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module odsc_serial_command #(
  parameter int CHANNELS = 8,
  parameter int CODE_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic serial_clk,
  input wire logic frame_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_en,
  input wire logic load_strobe_n,
  output logic [CHANNELS*CODE_W-1:0] converter_code,
  output logic [CHANNELS*CODE_W-1:0] input_code,
  output logic [2*CHANNELS-1:0] channel_power_mode_field,
  output logic [CHANNELS-1:0] channel_mask,
  output logic chain_mode_setting,
  output logic frame_done
);

  localparam int FB = `ODSC_FRAME_BITS;

  // ---------------- link domain (serial_clk) ----------------
  logic [FB-1:0] shift_word;
  logic [4:0] bit_count;
  logic link_out;
  logic [FB-1:0] readback_word;
  logic readback_active;
  wire logic [4:0] rb_index;
  wire logic rb_bit;
  wire logic next_link_out;

  // shifting halts as soon as select rises, so the word is static for the core
  always_ff @(negedge serial_clk or posedge rst) begin
    if (rst) begin
      shift_word <= '0;
    end else if (!frame_select_n) begin
      shift_word <= {shift_word[FB-2:0], serial_in}; // [RL2] [RL1] [RL13]
    end
  end

  // counter cleared by the frame's own select, so a stopped clock is harmless
  always_ff @(negedge serial_clk or posedge frame_select_n) begin
    if (frame_select_n) begin
      bit_count <= 5'h00;
    end else if (bit_count != 5'(FB)) begin
      bit_count <= bit_count + 5'h01;
    end
  end

  assign rb_index = 5'(FB - 1) - bit_count;
  assign rb_bit = (bit_count < 5'(FB)) ? readback_word[rb_index] : 1'b0;
  // readback wins over chain data for the frame after the arming command
  assign next_link_out = readback_active ? rb_bit : shift_word[FB-1]; // [RL17] [RL11]

  // launched on rising clock, valid at the next falling edge
  always_ff @(posedge serial_clk or posedge rst) begin
    if (rst) begin
      link_out <= 1'b0;
    end else if (!frame_select_n) begin
      link_out <= next_link_out; // [RL11] [RL18]
    end
  end

  assign serial_out = link_out;
  // pin keeps its last bit between frames; weak keeper is outside this logic
  assign serial_out_en = chain_mode_setting | readback_active; // [RL16] [RL18]

  // ---------------- core domain (sys_clk) ----------------
  logic sel_s1;
  logic sel_s2;
  logic sel_s3;
  logic ls_s1;
  logic ls_s2;
  logic ls_s3;
  logic [FB-1:0] frame_word;
  logic frame_pulse;
  logic [2:0] readback_sel;

  // two flops before any logic reads the pins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      sel_s3 <= 1'b1;
      ls_s1 <= 1'b1;
      ls_s2 <= 1'b1;
      ls_s3 <= 1'b1;
    end else begin
      sel_s1 <= frame_select_n;
      sel_s2 <= sel_s1;
      sel_s3 <= sel_s2;
      ls_s1 <= load_strobe_n;
      ls_s2 <= ls_s1;
      ls_s3 <= ls_s2;
    end
  end

  wire logic sel_rise;
  wire logic strobe_fall;
  wire logic strobe_low;
  assign sel_rise = sel_s2 & ~sel_s3; // [RL3] [RL4]
  assign strobe_fall = ls_s3 & ~ls_s2 & sel_s2; // [RL6] [RL25]
  assign strobe_low = ~ls_s2;

  // word captured once select is high; shifting has stopped by then
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      frame_word <= '0;
      frame_pulse <= 1'b0;
    end else begin
      frame_pulse <= sel_rise;
      if (sel_rise) begin
        frame_word <= shift_word; // [RL13] [RL4]
      end
    end
  end

  assign frame_done = frame_pulse;

  wire odsc_pkg::odsc_cmd_type cmd;
  wire logic [3:0] addr;
  wire logic [CODE_W-1:0] data;
  wire logic [CHANNELS-1:0] addr_sel;
  assign cmd = odsc_pkg::odsc_cmd_type'(frame_word[`ODSC_CMD_MSB:`ODSC_CMD_LSB]); // [RL1]
  assign addr = frame_word[`ODSC_ADDR_MSB:`ODSC_ADDR_LSB];
  assign data = frame_word[`ODSC_DATA_MSB:`ODSC_DATA_LSB];
  // binary channel address; codes at or above the channel count select nothing to write or update, but readback takes addr[2:0]
  assign addr_sel = (addr < 4'(CHANNELS)) ? (CHANNELS'(1) << addr) : '0;

  wire logic do_wr_in;
  wire logic do_upd;
  wire logic do_wr_upd;
  wire logic do_power;
  wire logic do_mask;
  wire logic do_chain;
  wire logic do_rb;
  wire logic do_all_in;
  wire logic do_all_both;
  // unlisted codes decode to nothing and so change nothing
  assign do_wr_in = frame_pulse && cmd == odsc_pkg::odsc_wr_in; // [RL7] [RL26]
  assign do_upd = frame_pulse && cmd == odsc_pkg::odsc_upd_conv; // [RL8]
  assign do_wr_upd = frame_pulse && cmd == odsc_pkg::odsc_wr_upd; // [RL9]
  assign do_power = frame_pulse && cmd == odsc_pkg::odsc_power; // [RL19]
  assign do_mask = frame_pulse && cmd == odsc_pkg::odsc_mask; // [RL24]
  assign do_chain = frame_pulse && cmd == odsc_pkg::odsc_chain; // [RL10]
  assign do_rb = frame_pulse && cmd == odsc_pkg::odsc_readback; // [RL15]
  assign do_all_in = frame_pulse && cmd == odsc_pkg::odsc_wr_all_in;
  assign do_all_both = frame_pulse && cmd == odsc_pkg::odsc_wr_all_both;

  // configuration registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      channel_power_mode_field <= `ODSC_RST_POWER;
      channel_mask <= `ODSC_RST_MASK;
      chain_mode_setting <= `ODSC_RST_CHAIN;
    end else begin
      if (do_power) begin
        channel_power_mode_field <= data[2*CHANNELS-1:0]; // [RL19] [RL20]
      end
      if (do_mask) begin
        channel_mask <= data[`ODSC_MASK_MSB:0]; // [RL24]
      end
      if (do_chain) begin
        chain_mode_setting <= data[`ODSC_CHAIN_BIT]; // [RL10]
      end
    end
  end

  // readback stays armed for exactly one following frame
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      readback_active <= 1'b0;
      readback_sel <= 3'h0;
    end else if (frame_pulse) begin
      readback_active <= do_rb; // [RL15] [RL16] [RL17]
      if (do_rb) begin
        readback_sel <= addr[2:0];
      end
    end
  end

  // word only changes after select rises, so it is static while the link reads it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      readback_word <= '0;
    end else begin
      readback_word <= '0;
      readback_word[`ODSC_RB_DATA_LSB +: CODE_W] <= input_code[readback_sel*CODE_W +: CODE_W]; // [RL17]
    end
  end

  // per channel input and converter stage
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
      logic [CODE_W-1:0] in_reg;
      logic [CODE_W-1:0] conv_reg;
      wire logic hit;
      wire logic write_in;
      wire logic write_conv;
      wire logic copy_conv;
      assign hit = addr_sel[ch];
      assign write_in = (do_wr_in & hit) | (do_wr_upd & hit) | do_all_in | do_all_both; // [RL7] [RL9]
      // strobe held low and unmasked: input stage is transparent
      assign write_conv = (do_wr_in & hit & strobe_low & ~channel_mask[ch]) // [RL22] [RL7]
                          | (do_wr_upd & hit) | do_all_both; // [RL9]
      assign copy_conv = (do_upd & hit) | (strobe_fall & ~channel_mask[ch]); // [RL8] [RL6] [RL25] [RL24]

      // power mode never gates these, codes persist and update while down
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          in_reg <= `ODSC_RST_CODE;
          conv_reg <= `ODSC_RST_CODE;
        end else begin
          if (write_in) begin
            in_reg <= data; // [RL23]
          end
          if (write_conv) begin
            conv_reg <= data; // [RL21] [RL23]
          end else if (copy_conv) begin
            conv_reg <= in_reg; // [RL23]
          end
        end
      end

      assign input_code[ch*CODE_W +: CODE_W] = in_reg;
      assign converter_code[ch*CODE_W +: CODE_W] = conv_reg;
    end
  endgenerate

endmodule

`default_nettype wire

// ---- logic/odsc_cfg.svh ----
// constants for the octal converter serial command logic
`ifndef ODSC_CFG_SVH
`define ODSC_CFG_SVH

// frame layout
`define ODSC_FRAME_BITS 24
`define ODSC_CMD_MSB 23
`define ODSC_CMD_LSB 20
`define ODSC_ADDR_MSB 19
`define ODSC_ADDR_LSB 16
`define ODSC_DATA_MSB 15
`define ODSC_DATA_LSB 0
`define ODSC_MASK_MSB 7
`define ODSC_CHAIN_BIT 0

// readback word placement
`define ODSC_RB_DATA_LSB 4

// command codes
`define ODSC_CMD_NOP 4'h0
`define ODSC_CMD_WR_IN 4'h1
`define ODSC_CMD_UPD_CONV 4'h2
`define ODSC_CMD_WR_UPD 4'h3
`define ODSC_CMD_POWER 4'h4
`define ODSC_CMD_MASK 4'h5
`define ODSC_CMD_CHAIN 4'h8
`define ODSC_CMD_READBACK 4'h9
`define ODSC_CMD_WR_ALL_IN 4'ha
`define ODSC_CMD_WR_ALL_BOTH 4'hb

// reset values
`define ODSC_RST_CODE 16'h0000
`define ODSC_RST_POWER 16'h0000
`define ODSC_RST_MASK 8'h00
`define ODSC_RST_CHAIN 1'b0

// least frame select high time between frames, ns
`define ODSC_GAP_NS 20
`define ODSC_SYS_NS 10
`define ODSC_GAP_CYCLES ((`ODSC_GAP_NS + `ODSC_SYS_NS - 1) / `ODSC_SYS_NS)

`endif

// ---- logic/odsc_pkg.sv ----
// types for the octal converter serial command logic
`include "odsc_cfg.svh"
`default_nettype none

package odsc_pkg;

  typedef enum logic [3:0] {
    odsc_nop = `ODSC_CMD_NOP,
    odsc_wr_in = `ODSC_CMD_WR_IN,
    odsc_upd_conv = `ODSC_CMD_UPD_CONV,
    odsc_wr_upd = `ODSC_CMD_WR_UPD,
    odsc_power = `ODSC_CMD_POWER,
    odsc_mask = `ODSC_CMD_MASK,
    odsc_chain = `ODSC_CMD_CHAIN,
    odsc_readback = `ODSC_CMD_READBACK,
    odsc_wr_all_in = `ODSC_CMD_WR_ALL_IN,
    odsc_wr_all_both = `ODSC_CMD_WR_ALL_BOTH
  } odsc_cmd_type;

  typedef enum logic [1:0] {
    odsc_pm_normal = 2'h0,
    odsc_pm_pull_gnd = 2'h1,
    odsc_pm_high_z = 2'h3
  } odsc_power_mode_type;

endpackage

`default_nettype wire

// ---- test/odsc_host.sv ----
// host model that drives gated serial frames and captures serial_out
`timescale 1ns/1ns
`default_nettype none
module odsc_host (
  output logic serial_clk,
  output logic frame_select_n,
  output logic serial_in,
  input wire logic serial_out
);
  initial begin
    serial_clk = 1'b0;
    frame_select_n = 1'b1;
    serial_in = 1'b0;
  end
  // clock stands low outside frames; 32 ns period inside
  task automatic send(input int n, input logic [47:0] w, output logic [47:0] rx);
    rx = '0;
    #3 frame_select_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = w[i];
      #8 serial_clk = 1'b1;
      #15 rx = {rx[46:0], serial_out};
      #1 serial_clk = 1'b0;
      #8;
    end
    frame_select_n = 1'b1;
    // released data line shows the inverse so a stale bit is never read as good
    serial_in = ~serial_in;
  endtask
endmodule
`default_nettype wire

// ---- test/odsc_chk.sv ----
// port assertions for the serial command logic
`timescale 1ns/1ns
`default_nettype none
module odsc_chk #(
  parameter int CHANNELS = 8,
  parameter int CODE_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic frame_select_n,
  input wire logic load_strobe_n,
  input wire logic serial_out,
  input wire logic serial_out_en,
  input wire logic [CHANNELS*CODE_W-1:0] converter_code,
  input wire logic [CHANNELS*CODE_W-1:0] input_code,
  input wire logic [2*CHANNELS-1:0] channel_power_mode_field,
  input wire logic chain_mode_setting,
  input wire logic frame_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_done_single: assert property (frame_done |=> !frame_done) else $error("done too long");
  a_done_delay: assert property ($rose(frame_select_n) |-> ##[1:5] frame_done) else $error("no done");
  a_done_deselect: assert property (frame_done |-> frame_select_n) else $error("done in frame");
  a_input_cause: assert property (!$stable(input_code) |-> $past(frame_done)) else $error("input moved");
  a_conv_cause: assert property (!$stable(converter_code) |-> $past(frame_done)
    || ($past(load_strobe_n, 6) && !$past(load_strobe_n, 2))) else $error("conv moved");
  a_power_cause: assert property (!$stable(channel_power_mode_field) |-> $past(frame_done))
    else $error("power moved");
  a_chain_enable: assert property (chain_mode_setting |-> serial_out_en) else $error("out off");
  a_out_hold: assert property (frame_select_n && $past(frame_select_n) |-> $stable(serial_out))
    else $error("out moved");
  cover property (frame_done && chain_mode_setting);
  cover property ($fell(load_strobe_n) && frame_select_n);
  cover property ($rose(serial_out_en) && !chain_mode_setting);
endmodule
bind odsc_serial_command odsc_chk #(.CHANNELS(CHANNELS), .CODE_W(CODE_W)) odsc_chk_inst (.sys_clk, .rst,
  .frame_select_n, .load_strobe_n, .serial_out, .serial_out_en, .converter_code, .input_code,
  .channel_power_mode_field, .chain_mode_setting, .frame_done);
`default_nettype wire

// ---- test/odsc_serial_command_test.sv ----
// self-checking bench for the serial command logic
`timescale 1ns/1ns
`default_nettype none
module odsc_serial_command_test;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic load_strobe_n = 1'b1;
  wire logic serial_clk, frame_select_n, serial_in, serial_out, serial_out_en, chain_mode_setting, frame_done;
  wire logic [127:0] converter_code, input_code;
  wire logic [15:0] channel_power_mode_field;
  wire logic [7:0] channel_mask;
  logic [47:0] rx;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  always #5 sys_clk = ~sys_clk;
  odsc_serial_command odsc_serial_command_inst (.sys_clk, .rst, .serial_clk, .frame_select_n, .serial_in,
    .serial_out, .serial_out_en, .load_strobe_n, .converter_code, .input_code, .channel_power_mode_field,
    .channel_mask, .chain_mode_setting, .frame_done);
  odsc_host odsc_host_inst (.serial_clk, .frame_select_n, .serial_in, .serial_out);
  function automatic logic [15:0] cv(input int ch);
    return converter_code[16*ch+:16];
  endfunction
  function automatic logic [15:0] iv(input int ch);
    return input_code[16*ch+:16];
  endfunction
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic frame(input int n, input logic [47:0] w);
    int k;
    k = 0;
    odsc_host_inst.send(n, w, rx);
    while (frame_done !== 1'b1 && k < 20) begin
      @(negedge sys_clk);
      k++;
    end
    check(24'(k < 20), 24'h1);
    // select stays high well past the capture of the word
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic strobe(input logic level);
    @(negedge sys_clk);
    load_strobe_n = level;
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic t_reset;
    check(converter_code[23:0] | input_code[23:0], 24'h0);
    check({channel_power_mode_field, channel_mask}, 24'h0);
    check({serial_out_en, chain_mode_setting}, 24'h0);
  endtask
  task automatic t_buffer;
    frame(24, 48'h12abcd);
    check(iv(2), 24'habcd);
    check(cv(2), 24'h0);
    strobe(1'b0);
    strobe(1'b1);
    check(cv(2), 24'habcd);
    frame(24, 48'h500004);
    frame(24, 48'h121234);
    strobe(1'b0);
    strobe(1'b1);
    check({channel_mask, cv(2)}, 24'h04abcd);
    frame(24, 48'h500000);
    frame(24, 48'h142222);
    frame(24, 48'h240000);
    check(cv(4), 24'h2222);
    frame(24, 48'h359999);
    check(cv(5), 24'h9999);
    check(iv(5), 24'h9999);
    strobe(1'b0);
    frame(24, 48'h135555);
    check(cv(3), 24'h5555);
    strobe(1'b1);
  endtask
  task automatic t_power_nop;
    logic [3:0] codes [7] = '{4'h0, 4'h6, 4'h7, 4'hc, 4'hd, 4'he, 4'hf};
    frame(24, 48'h40c3d1);
    check(channel_power_mode_field, 24'hc3d1);
    frame(24, 48'h300321);
    check(cv(0), 24'h0321);
    foreach (codes[i]) frame(24, {24'h0, codes[i], 20'h1ffff});
    check({iv(1), converter_code[23:16]}, 24'h0);
    check(channel_power_mode_field, 24'hc3d1);
    frame(24, 48'h400000);
  endtask
  task automatic t_short_read;
    frame(24, 48'h003712);
    // eight bits complete the word left behind by the last frame
    frame(8, 48'h34);
    check(cv(7), 24'h1234);
    frame(24, 48'h97abcd);
    check(serial_out_en, 24'h1);
    check(iv(7), 24'h1234);
    frame(24, 48'h0);
    check(rx[19:4], 24'h1234);
    check(serial_out_en, 24'h0);
  endtask
  task automatic t_chain;
    frame(24, 48'h800001);
    check({serial_out_en, chain_mode_setting}, 24'h3);
    frame(48, 48'h366666_000000);
    check(rx[47:24], 24'h800001);
    check(rx[23:0], 24'h366666);
    check(cv(6), 24'h0);
    frame(24, 48'h800000);
    check(chain_mode_setting, 24'h0);
  endtask
  task automatic t_all;
    frame(24, 48'ha0beef);
    check(iv(0), 24'hbeef);
    check(iv(7), 24'hbeef);
    check(cv(4), 24'h2222);
    frame(24, 48'hb0cafe);
    check(cv(6), 24'hcafe);
    check(iv(3), 24'hcafe);
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    t_reset();
    t_buffer();
    t_power_nop();
    t_short_read();
    t_chain();
    t_all();
    complete_run();
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("unexpected at %0t: timeout", $time);
      complete_run();
    end
  end
endmodule
`default_nettype wire
